// *** scan_consts.svh ***
// Constants for the linear array scan sequencer
`ifndef SCAN_CONSTS_SVH
`define SCAN_CONSTS_SVH
`define SCAN_POSITIONS 132
`define LEAD_DUMMIES 2
`define REAL_PIXELS 128
`define RESET_END_CLOCK 18
`define SETTLE_TIME_NS 10000
`define CLK_FREQ_MHZ 250
`define SETTLE_CYCLES ((`SETTLE_TIME_NS * `CLK_FREQ_MHZ + 999) / 1000)
`define POS_WIDTH 8
`endif

// *** scan_pkg.sv ***
// Types shared by the scan sequencer files
package scan_pkg;
   typedef enum logic [1:0] {
      phase_power_up = 2'b00,
      phase_int_reset = 2'b01,
      phase_integrate = 2'b10
   } phase_type;
endpackage

// *** token_shift.sv ***
// Token shift register that walks the scan-start bit through the positions
`timescale 1ns/1ps
module token_shift #(
   parameter int LEN = 132
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic shift_en,
   input wire logic load,
   output logic [LEN-1:0] token
);
   // --------------------------------------------------------------
   // One stage per position
   // --------------------------------------------------------------
   genvar i;
   generate
      for (i = 0; i < LEN; i = i + 1) begin : g_stage
         logic next_bit;
         if (i == 0) begin : g_head
            assign next_bit = load;
         end else begin : g_body
            assign next_bit = load ? 1'b0 : token[i-1];
         end
         always_ff @(posedge clk) begin
            if (sys_rst) begin
               token[i] <= 1'b0;
            end else if (shift_en) begin
               token[i] <= next_bit;
            end
         end
      end
   endgenerate
endmodule

// *** linear_array_scan_sequencer.sv ***
// Scan and integration sequencer of a 132-position linear photodiode array
// --------------------------------------------------------------
// --------------------------------------------------------------
`timescale 1ns/1ps
`include "scan_consts.svh"
module linear_array_scan_sequencer #(
   parameter int POSITIONS = `SCAN_POSITIONS,
   parameter int SETTLE_CYCLES = `SETTLE_CYCLES
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic scan_start_pin,
   input wire logic array_clk_pin,
   output logic analog_pixel_output_oe,
   output logic [`POS_WIDTH-1:0] analog_pixel_output_sel,
   output logic dummy_position,
   output logic sample_connect,
   output logic integrator_reset,
   output logic integrating,
   output logic scan_valid,
   output logic settle_done
);
   import scan_pkg::*;

   // --------------------------------------------------------------
   // Pin synchronisers
   // --------------------------------------------------------------
   // Both pins pass two flops, so start and clock keep their skew
   logic start_meta, start_sync;
   logic aclk_meta, aclk_sync, aclk_prev;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         start_meta <= 1'b0;
         start_sync <= 1'b0;
         aclk_meta <= 1'b0;
         aclk_sync <= 1'b0;
         aclk_prev <= 1'b0;
      end else begin
         start_meta <= scan_start_pin;
         start_sync <= start_meta;
         aclk_meta <= array_clk_pin;
         aclk_sync <= aclk_meta;
         aclk_prev <= aclk_sync;
      end
   end

   // --------------------------------------------------------------
   // Edge decode
   // --------------------------------------------------------------
   wire aclk_rise = aclk_sync & ~aclk_prev;
   wire aclk_fall = ~aclk_sync & aclk_prev;
   wire load = aclk_rise & start_sync;

   logic [POSITIONS-1:0] token;
   token_shift #(
      .LEN(POSITIONS)
   ) u_token (
      .clk(clk),
      .sys_rst(sys_rst),
      .shift_en(aclk_rise),
      .load(load),
      .token(token)
   );

   // Load clears every later stage, so a restart leaves one token
   // Token in the last stage leaves on clock 133
   wire last_out = aclk_rise & token[POSITIONS-1] & ~load;
   wire still_busy = |token[POSITIONS-2:0];
   // output driven only while a value remains
   wire next_oe = load | still_busy;

   localparam logic [`POS_WIDTH-1:0] idle_pos = `POS_WIDTH'h00;
   localparam logic [`POS_WIDTH-1:0] one_pos = `POS_WIDTH'h01;
   localparam logic [`POS_WIDTH-1:0] last_lead = `POS_WIDTH'(`LEAD_DUMMIES);
   localparam logic [`POS_WIDTH-1:0] first_tail =
      `POS_WIDTH'(`LEAD_DUMMIES + `REAL_PIXELS + 1);
   localparam logic [`POS_WIDTH-1:0] reset_end =
      `POS_WIDTH'(`RESET_END_CLOCK);

   // A start seen mid-scan simply restarts the walk at position 1
   wire [`POS_WIDTH-1:0] next_sel = load ? one_pos :
      (still_busy ? analog_pixel_output_sel + one_pos : idle_pos);
   // two dummies each side of 128 pixels
   wire lead_dummy = (next_sel != idle_pos) && (next_sel <= last_lead);
   wire tail_dummy = (next_sel >= first_tail);
   wire next_dummy = lead_dummy | tail_dummy;

   // --------------------------------------------------------------
   // Output position and drive
   // --------------------------------------------------------------
   // Position and drive move only on a detected array clock rise
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         analog_pixel_output_oe <= 1'b0;
         analog_pixel_output_sel <= `POS_WIDTH'h00;
         dummy_position <= 1'b0;
      end else if (aclk_rise) begin
         analog_pixel_output_oe <= next_oe;
         analog_pixel_output_sel <= next_sel;
         dummy_position <= next_dummy;
      end
   end

   // --------------------------------------------------------------
   // Integration phase
   // --------------------------------------------------------------
   // Release waits for the falling edge, so clock 18 stays in reset
   phase_type phase, next_phase;
   wire reset_done = aclk_fall && (analog_pixel_output_sel == reset_end)
      && (phase == phase_int_reset);

   always_comb begin
      next_phase = phase;
      case (phase)
         phase_power_up: begin
            if (load) begin
               next_phase = phase_int_reset;
            end
         end
         phase_int_reset: begin
            if (load) begin
               next_phase = phase_int_reset;
            end else if (reset_done) begin
               next_phase = phase_integrate;
            end
         end
         phase_integrate: begin
            if (load) begin
               next_phase = phase_int_reset;
            end
         end
         default: begin
            next_phase = phase_power_up;
         end
      endcase
   end

   // Caps and integration share one decode so they never disagree
   wire next_in_reset = (next_phase == phase_int_reset);
   wire next_integrating = (next_phase == phase_integrate);

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         phase <= phase_power_up;
         sample_connect <= 1'b0;
         integrator_reset <= 1'b0;
         integrating <= 1'b0;
      end else begin
         phase <= next_phase;
         sample_connect <= next_integrating;
         integrator_reset <= next_in_reset;
         integrating <= next_integrating;
      end
   end

   // --------------------------------------------------------------
   // Power-up validity and hold settle timer
   // --------------------------------------------------------------
   // Counts from the re-arm edge; the pin clock period is unknown here,
   // so the timer only promises the minimum gap, not the real one
   logic [15:0] settle_cnt;
   logic init_scan_done;

   wire settle_running = (settle_cnt != 16'h0000);
   wire settle_final = (settle_cnt == 16'h0001);
   wire [15:0] settle_reload = 16'(SETTLE_CYCLES);
   wire [15:0] settle_step = settle_cnt - 16'h0001;
   // A start mid-count wins: the timer only guards the re-arm gap
   wire settle_cancel = load;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         init_scan_done <= 1'b0;
         scan_valid <= 1'b0;
         settle_cnt <= 16'h0000;
         settle_done <= 1'b0;
      end else begin
         if (last_out) begin
            init_scan_done <= 1'b1;
         end
         if (load) begin
            scan_valid <= init_scan_done;
         end
         // one-cycle pulse when hold has settled
         if (settle_cancel) begin
            settle_cnt <= 16'h0000;
            settle_done <= 1'b0;
         end else if (last_out) begin
            settle_cnt <= settle_reload;
            settle_done <= 1'b0;
         end else if (settle_running) begin
            settle_cnt <= settle_step;
            settle_done <= settle_final;
         end else begin
            settle_done <= 1'b0;
         end
      end
   end
endmodule

// *** scan_seq_checker.sv ***
// Checker watching the scan sequencer ports
`timescale 1ns/1ps
`include "scan_consts.svh"
module scan_seq_checker #(
   parameter int SETTLE_CYCLES = 8
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic analog_pixel_output_oe,
   input wire logic [`POS_WIDTH-1:0] analog_pixel_output_sel,
   input wire logic dummy_position,
   input wire logic sample_connect,
   input wire logic integrator_reset,
   input wire logic integrating,
   input wire logic settle_done
);
   // Settle pulse may land one edge early or two late of the count
   localparam int SLO = SETTLE_CYCLES - 1;
   localparam int SHI = SETTLE_CYCLES + 2;
   wire logic oe = analog_pixel_output_oe;
   wire logic [`POS_WIDTH-1:0] sel = analog_pixel_output_sel;
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   a_load_opens_caps: assert property ($rose(oe) |-> sel == 8'h01
      && integrator_reset && !sample_connect && !integrating)
      else $error("load did not open caps");
   a_sel_steps_one: assert property ($changed(sel) && sel != 0
      && $past(sel) != 0 |-> sel == $past(sel) + 8'h01)
      else $error("position skipped");
   a_dummy_at_ends: assert property (dummy_position == (oe
      && (sel <= 8'h02 || sel >= 8'h83))) else $error("dummy flag wrong");
   a_last_clock_idle: assert property ($fell(oe) |->
      $past(sel) == 8'h84 && sel == 8'h00) else $error("early release");
   a_reset_span: assert property ($fell(integrator_reset)
      |-> sel == 8'h12) else $error("reset ended off clock 18");
   a_caps_pair: assert property (integrating == sample_connect)
      else $error("caps and integration differ");
   a_oe_tracks_sel: assert property (oe == (sel != 8'h00))
      else $error("output enable wrong");
   a_settle_due: assert property ($fell(oe) |->
      ##[SLO:SHI] settle_done) else $error("settle pulse missing");
   a_settle_single: assert property (settle_done |=> !settle_done)
      else $error("settle pulse too long");
endmodule
bind linear_array_scan_sequencer scan_seq_checker #(
   .SETTLE_CYCLES(SETTLE_CYCLES)
) i_chk (.clk(clk), .sys_rst(sys_rst), .settle_done(settle_done),
   .analog_pixel_output_oe(analog_pixel_output_oe),
   .analog_pixel_output_sel(analog_pixel_output_sel),
   .dummy_position(dummy_position), .sample_connect(sample_connect),
   .integrator_reset(integrator_reset), .integrating(integrating));

// *** scan_ctrl_model.sv ***
// Behavioural scan controller driving start and array clock pins
`timescale 1ns/1ps
module scan_ctrl_model #(
   parameter int GAP = 20
) (
   input wire logic clk,
   input wire logic go,
   input wire logic [3:0] half,
   output logic scan_start_pin,
   output logic array_clk_pin,
   output logic busy
);
   initial begin
      scan_start_pin = 0;
      array_clk_pin = 0;
      busy = 0;
      forever begin
         @(posedge clk);
         if (go) begin
            busy <= 1;
            scan_start_pin <= 1;
            for (int n = 1; n <= 133; n++) begin
               repeat (half) @(posedge clk);
               array_clk_pin <= 1;
               repeat (half) @(posedge clk);
               array_clk_pin <= 0;
               if (n == 1) scan_start_pin <= 0;
            end
            // settle gap, longer than the shortened count
            repeat (GAP) @(posedge clk);
            busy <= 0;
         end
      end
   end
endmodule

// *** tb_linear_array_scan_sequencer.sv ***
// Self-checking bench for the scan sequencer
`timescale 1ns/1ps
`include "scan_consts.svh"
module tb_linear_array_scan_sequencer;
   localparam int SCANS = 4;
   logic clk, sys_rst, go, start, aclk, busy, oe, dum, sc, ir, intg;
   logic vld, sd, expv;
   logic [`POS_WIDTH-1:0] sel, last;
   logic [3:0] half;
   int errors, checks_done, scans, seed, k, pulses;
   linear_array_scan_sequencer #(.SETTLE_CYCLES(8)) i_dut (.clk(clk),
      .sys_rst(sys_rst), .scan_start_pin(start), .array_clk_pin(aclk),
      .analog_pixel_output_oe(oe), .analog_pixel_output_sel(sel),
      .dummy_position(dum), .sample_connect(sc), .integrator_reset(ir),
      .integrating(intg), .scan_valid(vld), .settle_done(sd));
   scan_ctrl_model i_ctrl (.clk(clk), .go(go), .half(half),
      .scan_start_pin(start), .array_clk_pin(aclk), .busy(busy));
   task automatic check(input logic [7:0] seen, input logic [7:0] want);
      checks_done++;
      if (seen !== want) begin
         errors++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, want);
      end
   endtask
   function automatic logic is_dummy(input logic [7:0] p);
      return p != 0 && (p <= `LEAD_DUMMIES
         || p > `LEAD_DUMMIES + `REAL_PIXELS);
   endfunction
   task automatic close_out();
      $display("errors %0d checks %0d", errors, checks_done);
      if (errors == 0 && checks_done > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   initial begin
      clk = 0;
      forever #2 clk = ~clk;
   end
   // Outputs are settled by the falling edge
   always @(negedge clk) if (!sys_rst && sel !== last) begin
      check(sel, last == `SCAN_POSITIONS ? 8'h00 : last + 8'h01);
      check(dum, is_dummy(sel));
      check(ir, sel >= 1 && sel <= `RESET_END_CLOCK);
      check(oe, sel != 0);
      if (sel == 0) scans++;
      check(intg, sel > `RESET_END_CLOCK || (sel == 0 && scans > 0));
      check(sc, sel > `RESET_END_CLOCK || (sel == 0 && scans > 0));
      if (sel == 1) expv = scans > 0;
      check(vld, expv);
      last = sel;
   end
   always @(negedge clk) if (!sys_rst && sd) pulses++;
   initial begin
      sys_rst = 1;
      go = 0;
      half = 4'h4;
      seed = 66772;
      last = 0;
      expv = 0;
      repeat (10) @(posedge clk);
      sys_rst <= 0;
      // Fastest and slowest clocks first, then random pacing
      for (int i = 0; i < SCANS; i++) begin
         half <= i == 0 ? 4'h3 : i == 1 ? 4'hA : 4'h3 + 4'($random(seed) & 3);
         go <= 1;
         @(posedge clk);
         go <= 0;
         @(posedge clk);
         k = 0;
         while (busy && k < 5000) begin
            @(posedge clk);
            k++;
         end
         if (k >= 5000) errors++;
      end
      check(scans, SCANS);
      check(pulses, SCANS);
      close_out();
   end
   initial begin
      #200000;
      errors++;
      close_out();
   end
endmodule
